// *** src/clock_synth_config_regs.sv ***
// two-wire bus slave and configuration registers of the clock synthesizer
`timescale 1ns/1ps
`include "clock_synth_cfg_defs.svh"
module clock_synth_config_regs
	import clock_synth_cfg_pkg::*;
#(
	parameter logic [6:0] SLAVE_ADDR = 7'h5a,
	parameter int N_DEFAULT = 0,
	parameter int M_DEFAULT = 0,
	parameter int SPREAD_DEFAULT = 0
) (
	input wire logic clk_sys_i, // system clock 200 MHz
	input wire logic rst_n_i, // async reset, active low
	input wire logic smb_clk_i, // bus clock line
	input wire logic smb_data_i, // bus data line level
	output logic smb_data_o, // bus data drive value
	output logic smb_data_oe_n_o, // low while pulling data low
	output logic ref_out0_drive_select_o, // 1 double drive
	output logic ref_out1_drive_select_o, // 1 double drive
	output logic ref_out2_drive_select_o, // 1 double drive
	output logic usb_clk0_drive_select_o, // 1 double drive
	output logic usb_clk1_drive_select_o, // 1 double drive
	output logic [3:0] graphics_freq_select_o, // graphics frequency code
	output logic divider_program_enable_o, // dividers programmable
	output logic [9:0] feedback_divider_o, // n divider in use
	output logic [5:0] reference_divider_o, // m divider in use
	output logic [10:0] vco_multiplier_o, // n plus 8
	output logic [6:0] vco_divisor_o, // m plus 2
	output logic [14:0] spread_amount_o // spread field
);
	// ----------------------------------------------------------------
	// parameter checks
	// ----------------------------------------------------------------
	if (N_DEFAULT < 0 || N_DEFAULT > 1023) begin : g_bad_n
		$error("N_DEFAULT must fit ten bits");
	end
	if (M_DEFAULT < 0 || M_DEFAULT > 63) begin : g_bad_m
		$error("M_DEFAULT must fit six bits");
	end
	if (SPREAD_DEFAULT < 0 || SPREAD_DEFAULT > 32767) begin : g_bad_spread
		$error("SPREAD_DEFAULT must fit fifteen bits");
	end

	localparam logic [9:0] N_RST = 10'(N_DEFAULT);
	localparam logic [5:0] M_RST = 6'(M_DEFAULT);
	localparam logic [14:0] SPREAD_RST = 15'(SPREAD_DEFAULT);

	// ----------------------------------------------------------------
	// line events
	// ----------------------------------------------------------------
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	line_watch u_line_watch (
		.clk_sys_i (clk_sys_i),
		.rst_n_i (rst_n_i),
		.scl_i (smb_clk_i),
		.sda_i (smb_data_i),
		.scl_rise_o (scl_rise),
		.scl_fall_o (scl_fall),
		.start_o (bus_start),
		.stop_o (bus_stop)
	);

	// ----------------------------------------------------------------
	// byte engine
	// ----------------------------------------------------------------
	cfg_access_if cfg ();

	link_st_s st;
	link_st_s next_st;

	function automatic logic byte_done(input logic [3:0] cnt);
		byte_done = (cnt == `BITS_PER_BYTE);
	endfunction : byte_done

	always_comb begin
		next_st = st;
		next_st.wr_pulse = 1'b0;
		// pointer steps once the written byte has landed
		if (st.wr_pulse) begin
			next_st.pointer = st.pointer + 8'h01;
		end
		if (scl_rise && st.state != S_RDATA && st.state != S_RDATA_ACK) begin
			next_st.shreg = {st.shreg[6:0], smb_data_i};
			next_st.bitcnt = st.bitcnt + 4'h1;
		end
		unique case (st.state)
			S_IDLE: begin
				next_st.sda_oe_n = 1'b1;
			end
			S_ADDR: begin
				if (scl_fall && byte_done(st.bitcnt)) begin
					if (st.shreg[7:1] == SLAVE_ADDR) begin
						next_st.rw = st.shreg[0];
						next_st.sda_oe_n = 1'b0;
						next_st.state = S_ADDR_ACK;
					end else begin
						next_st.state = S_IDLE;
					end
				end
			end
			S_ADDR_ACK: begin
				if (scl_fall) begin
					next_st.bitcnt = 4'h0;
					if (st.rw) begin
						next_st.tx = cfg.rdata;
						next_st.sda_oe_n = cfg.rdata[7];
						next_st.state = S_RDATA;
					end else begin
						next_st.sda_oe_n = 1'b1;
						next_st.state = S_CMD;
					end
				end
			end
			S_CMD: begin
				if (scl_fall && byte_done(st.bitcnt)) begin
					next_st.pointer = st.shreg;
					next_st.sda_oe_n = 1'b0;
					next_st.state = S_CMD_ACK;
				end
			end
			S_CMD_ACK, S_WDATA_ACK: begin
				if (scl_fall) begin
					next_st.bitcnt = 4'h0;
					next_st.sda_oe_n = 1'b1;
					next_st.state = S_WDATA;
				end
			end
			S_WDATA: begin
				if (scl_fall && byte_done(st.bitcnt)) begin
					// unmapped offsets are acknowledged and dropped
					next_st.wr_pulse = 1'b1;
					next_st.sda_oe_n = 1'b0;
					next_st.state = S_WDATA_ACK;
				end
			end
			S_RDATA: begin
				if (scl_rise) begin
					next_st.bitcnt = st.bitcnt + 4'h1;
				end
				if (scl_fall) begin
					if (byte_done(st.bitcnt)) begin
						next_st.sda_oe_n = 1'b1;
						next_st.pointer = st.pointer + 8'h01;
						next_st.bitcnt = 4'h0;
						next_st.state = S_RDATA_ACK;
					end else begin
						next_st.tx = {st.tx[6:0], 1'b0};
						next_st.sda_oe_n = st.tx[6];
					end
				end
			end
			S_RDATA_ACK: begin
				if (scl_rise) begin
					next_st.ack = ~smb_data_i;
				end
				if (scl_fall) begin
					if (st.ack) begin
						next_st.tx = cfg.rdata;
						next_st.sda_oe_n = cfg.rdata[7];
						next_st.state = S_RDATA;
					end else begin
						next_st.state = S_IDLE;
					end
				end
			end
		endcase
		// start and stop override any byte in progress
		if (bus_start) begin
			next_st.state = S_ADDR;
			next_st.bitcnt = 4'h0;
			next_st.sda_oe_n = 1'b1;
		end else if (bus_stop) begin
			next_st.state = S_IDLE;
			next_st.sda_oe_n = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '{state: S_IDLE, shreg: 8'h00, tx: 8'h00, bitcnt: 4'h0, rw: 1'b0,
				ack: 1'b0, pointer: 8'h00, wr_pulse: 1'b0, sda_oe_n: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	assign cfg.wr_en = st.wr_pulse;
	assign cfg.addr = st.pointer;
	assign cfg.wdata = st.shreg;
	assign smb_data_o = 1'b0;
	assign smb_data_oe_n_o = st.sda_oe_n;

	// ----------------------------------------------------------------
	// register bank
	// ----------------------------------------------------------------
	logic [7:0] drive_gfx;
	logic [7:0] enable_ref;

	cfg_reg_bank #(
		.N_DEFAULT (N_RST),
		.M_DEFAULT (M_RST),
		.SPREAD_DEFAULT (SPREAD_RST)
	) u_cfg_reg_bank (
		.clk_sys_i (clk_sys_i),
		.rst_n_i (rst_n_i),
		.cfg (cfg),
		.drive_gfx_o (drive_gfx),
		.enable_ref_o (enable_ref),
		.feedback_divider_o (feedback_divider_o),
		.reference_divider_o (reference_divider_o),
		.spread_amount_o (spread_amount_o)
	);

	assign ref_out2_drive_select_o = drive_gfx[`POS_REF2_DRIVE];
	assign usb_clk1_drive_select_o = drive_gfx[`POS_USB1_DRIVE];
	assign usb_clk0_drive_select_o = drive_gfx[`POS_USB0_DRIVE];
	assign graphics_freq_select_o = drive_gfx[`POS_GFX_MSB:0];
	assign divider_program_enable_o = enable_ref[`POS_MN_ENABLE];
	assign ref_out1_drive_select_o = enable_ref[`POS_REF1_DRIVE];
	assign ref_out0_drive_select_o = enable_ref[`POS_REF0_DRIVE];
	// oscillator = reference x multiplier / divisor
	assign vco_multiplier_o = {1'b0, feedback_divider_o} + `N_ADD;
	assign vco_divisor_o = {1'b0, reference_divider_o} + `M_ADD;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	sequence addr_match_s;
		st.state == S_ADDR && scl_fall && byte_done(st.bitcnt)
			&& st.shreg[7:1] == SLAVE_ADDR && !bus_start && !bus_stop;
	endsequence

	sequence data_byte_end_s;
		st.state == S_WDATA && scl_fall && byte_done(st.bitcnt) && !bus_start && !bus_stop;
	endsequence

	addr_ack_drive_a: assert property (addr_match_s |=>
		(st.state == S_ADDR_ACK && !smb_data_oe_n_o))
		else $error("own address not acknowledged");
	write_strobe_a: assert property (data_byte_end_s |=> cfg.wr_en ##1 !cfg.wr_en)
		else $error("write strobe not one cycle");
	pointer_step_a: assert property (cfg.wr_en |=> (cfg.addr == $past(cfg.addr) + 8'h01))
		else $error("pointer not advanced after write");
	stop_release_a: assert property (bus_stop |=> (st.state == S_IDLE && smb_data_oe_n_o))
		else $error("data line held after stop");
	vco_terms_a: assert property ((vco_multiplier_o == 11'h008 +
		(divider_program_enable_o ? {1'b0, u_cfg_reg_bank.st.m_n_high[6],
		u_cfg_reg_bank.st.m_n_high[7], u_cfg_reg_bank.st.n_low} : {1'b0, N_RST}))
		&& (vco_divisor_o == 7'h02 +
		(divider_program_enable_o ? {1'b0, u_cfg_reg_bank.st.m_n_high[5:0]} : {1'b0, M_RST})))
		else $error("oscillator terms wrong");
	m_field_a: assert property (divider_program_enable_o |->
		(reference_divider_o == u_cfg_reg_bank.st.m_n_high[5:0]))
		else $error("m divider not from low bits");

	// ----------------------------------------------------------------
	// line turnaround checks
	// ----------------------------------------------------------------
	sequence read_turn_s;
		((st.state == S_ADDR_ACK && st.rw) || (st.state == S_RDATA_ACK && st.ack))
			&& scl_fall && !bus_start && !bus_stop;
	endsequence

	sequence read_byte_end_s;
		st.state == S_RDATA && scl_fall && byte_done(st.bitcnt) && !bus_start && !bus_stop;
	endsequence

	sequence ack_end_s;
		((st.state == S_ADDR_ACK && !st.rw) || st.state == S_CMD_ACK || st.state == S_WDATA_ACK)
			&& scl_fall && !bus_start && !bus_stop;
	endsequence

	sequence foreign_addr_s;
		st.state == S_ADDR && scl_fall && byte_done(st.bitcnt)
			&& st.shreg[7:1] != SLAVE_ADDR && !bus_start && !bus_stop;
	endsequence

	// first data bit goes out one cycle after the clock fall
	read_first_bit_a: assert property (read_turn_s |=>
		(st.state == S_RDATA && smb_data_oe_n_o == $past(cfg.rdata[7])))
		else $error("first read bit not driven");
	read_release_a: assert property (read_byte_end_s |=>
		(st.state == S_RDATA_ACK && smb_data_oe_n_o && cfg.addr == $past(cfg.addr) + 8'h01))
		else $error("read byte end wrong");
	read_hold_a: assert property ((st.state == S_RDATA && smb_clk_i) |-> $stable(smb_data_oe_n_o))
		else $error("read bit moved while clock high");
	ack_release_a: assert property (ack_end_s |=> (smb_data_oe_n_o && st.bitcnt == 4'h0))
		else $error("acknowledge not released");
	foreign_addr_a: assert property (foreign_addr_s |=> (st.state == S_IDLE && smb_data_oe_n_o))
		else $error("foreign address acknowledged");
	start_restart_a: assert property (bus_start |=>
		(st.state == S_ADDR && st.bitcnt == 4'h0 && smb_data_oe_n_o))
		else $error("start did not restart byte");
	idle_released_a: assert property (st.state == S_IDLE |-> smb_data_oe_n_o)
		else $error("data line held while idle");
	strobe_state_a: assert property (cfg.wr_en |->
		(st.state == S_WDATA_ACK && !smb_data_oe_n_o))
		else $error("write strobe outside data acknowledge");
	unmapped_zero_a: assert property (
		(cfg.addr < `OFS_DRIVE_GFX || cfg.addr > `OFS_SPREAD_HIGH) |-> (cfg.rdata == 8'h00))
		else $error("unmapped offset reads nonzero");
endmodule : clock_synth_config_regs

// *** src/clock_synth_cfg_defs.svh ***
// register offsets, field positions, reset values and constants of the config bank
`ifndef CLOCK_SYNTH_CFG_DEFS_SVH
`define CLOCK_SYNTH_CFG_DEFS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_DRIVE_GFX 8'h09
`define OFS_ENABLE_REF 8'h0a
`define OFS_M_N_HIGH 8'h0b
`define OFS_N_LOW 8'h0c
`define OFS_SPREAD_LOW 8'h0d
`define OFS_SPREAD_HIGH 8'h0e

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define POS_REF2_DRIVE 7
`define POS_USB1_DRIVE 6
`define POS_USB0_DRIVE 5
`define POS_GFX_MSB 3
`define POS_MN_ENABLE 7
`define POS_REF1_DRIVE 6
`define POS_REF0_DRIVE 5
`define POS_N_BIT8 7
`define POS_N_BIT9 6
`define POS_M_MSB 5
`define POS_SPREAD_HIGH_MSB 6

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define RST_DRIVE_GFX 8'he0
`define RST_ENABLE_REF 8'h60
`define MASK_DRIVE_GFX 8'hef
`define MASK_ENABLE_REF 8'he0
`define MASK_SPREAD_HIGH 8'h7f

// ----------------------------------------------------------------
// oscillator equation terms
// ----------------------------------------------------------------
`define REF_FREQ_KHZ 14318
`define N_ADD 11'h008
`define M_ADD 7'h02

// ----------------------------------------------------------------
// serial bus
// ----------------------------------------------------------------
`define BITS_PER_BYTE 4'h8

`endif

// *** src/clock_synth_cfg_pkg.sv ***
// types shared by the configuration bank modules
package clock_synth_cfg_pkg;

	typedef enum logic [8:0] {
		S_IDLE = 9'h001,
		S_ADDR = 9'h002,
		S_ADDR_ACK = 9'h004,
		S_CMD = 9'h008,
		S_CMD_ACK = 9'h010,
		S_WDATA = 9'h020,
		S_WDATA_ACK = 9'h040,
		S_RDATA = 9'h080,
		S_RDATA_ACK = 9'h100
	} link_state_e;

	typedef struct packed {
		link_state_e state;
		logic [7:0] shreg;
		logic [7:0] tx;
		logic [3:0] bitcnt;
		logic rw;
		logic ack;
		logic [7:0] pointer;
		logic wr_pulse;
		logic sda_oe_n;
	} link_st_s;

	typedef struct packed {
		logic scl_q;
		logic sda_q;
	} watch_st_s;

	typedef struct packed {
		logic [7:0] drive_gfx;
		logic [7:0] enable_ref;
		logic [7:0] m_n_high;
		logic [7:0] n_low;
		logic [7:0] spread_low;
		logic [7:0] spread_high;
	} bank_st_s;

endpackage : clock_synth_cfg_pkg

// *** src/cfg_access_if.sv ***
// byte access path between the serial engine and the register bank
`timescale 1ns/1ps
interface cfg_access_if;
	logic wr_en;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	modport master (output wr_en, output addr, output wdata, input rdata);
	modport bank (input wr_en, input addr, input wdata, output rdata);
endinterface : cfg_access_if

// *** src/line_watch.sv ***
// edge and start/stop detection on the two-wire bus lines
`timescale 1ns/1ps
`include "clock_synth_cfg_defs.svh"
module line_watch
	import clock_synth_cfg_pkg::*;
(
	input wire logic clk_sys_i, // system clock
	input wire logic rst_n_i, // async reset
	input wire logic scl_i, // bus clock level
	input wire logic sda_i, // bus data level
	output logic scl_rise_o, // bus clock rose
	output logic scl_fall_o, // bus clock fell
	output logic start_o, // start or repeated start
	output logic stop_o // stop condition
);
	watch_st_s st;
	watch_st_s next_st;

	always_comb begin
		next_st.scl_q = scl_i;
		next_st.sda_q = sda_i;
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st <= '{scl_q: 1'b1, sda_q: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	assign scl_rise_o = scl_i & ~st.scl_q;
	assign scl_fall_o = ~scl_i & st.scl_q;
	assign start_o = scl_i & st.scl_q & st.sda_q & ~sda_i;
	assign stop_o = scl_i & st.scl_q & ~st.sda_q & sda_i;
endmodule : line_watch

// *** src/cfg_reg_bank.sv ***
// configuration byte registers and the divider outputs they steer
`timescale 1ns/1ps
`include "clock_synth_cfg_defs.svh"
module cfg_reg_bank
	import clock_synth_cfg_pkg::*;
#(
	parameter logic [9:0] N_DEFAULT = 10'h000,
	parameter logic [5:0] M_DEFAULT = 6'h00,
	parameter logic [14:0] SPREAD_DEFAULT = 15'h0000
) (
	input wire logic clk_sys_i, // system clock
	input wire logic rst_n_i, // async reset
	cfg_access_if.bank cfg, // byte access
	output logic [7:0] drive_gfx_o, // drive and graphics byte
	output logic [7:0] enable_ref_o, // enable and ref drive byte
	output logic [9:0] feedback_divider_o, // n divider in use
	output logic [5:0] reference_divider_o, // m divider in use
	output logic [14:0] spread_amount_o // spread field
);
	bank_st_s st;
	bank_st_s next_st;
	logic [7:0] wmasked;

	always_comb begin
		next_st = st;
		wmasked = cfg.wdata;
		if (cfg.wr_en) begin
			unique case (cfg.addr)
				`OFS_DRIVE_GFX: next_st.drive_gfx = wmasked & `MASK_DRIVE_GFX;
				`OFS_ENABLE_REF: next_st.enable_ref = wmasked & `MASK_ENABLE_REF;
				`OFS_M_N_HIGH: next_st.m_n_high = wmasked;
				`OFS_N_LOW: next_st.n_low = wmasked;
				`OFS_SPREAD_LOW: next_st.spread_low = wmasked;
				`OFS_SPREAD_HIGH: next_st.spread_high = wmasked & `MASK_SPREAD_HIGH;
				default: next_st = st;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st.drive_gfx <= `RST_DRIVE_GFX;
			st.enable_ref <= `RST_ENABLE_REF;
			st.m_n_high <= {N_DEFAULT[8], N_DEFAULT[9], M_DEFAULT};
			st.n_low <= N_DEFAULT[7:0];
			st.spread_low <= SPREAD_DEFAULT[7:0];
			st.spread_high <= {1'b0, SPREAD_DEFAULT[14:8]};
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------------------------------
	// read mux, unmapped offsets read zero
	// ----------------------------------------------------------------
	always_comb begin
		unique case (cfg.addr)
			`OFS_DRIVE_GFX: cfg.rdata = st.drive_gfx;
			`OFS_ENABLE_REF: cfg.rdata = st.enable_ref;
			`OFS_M_N_HIGH: cfg.rdata = st.m_n_high;
			`OFS_N_LOW: cfg.rdata = st.n_low;
			`OFS_SPREAD_LOW: cfg.rdata = st.spread_low;
			`OFS_SPREAD_HIGH: cfg.rdata = st.spread_high;
			default: cfg.rdata = 8'h00;
		endcase
	end

	// programmed dividers apply only while enabled
	assign feedback_divider_o = st.enable_ref[`POS_MN_ENABLE] ?
		{st.m_n_high[`POS_N_BIT9], st.m_n_high[`POS_N_BIT8], st.n_low} : N_DEFAULT;
	assign reference_divider_o = st.enable_ref[`POS_MN_ENABLE] ?
		st.m_n_high[`POS_M_MSB:0] : M_DEFAULT;
	assign spread_amount_o = {st.spread_high[`POS_SPREAD_HIGH_MSB:0], st.spread_low};
	assign drive_gfx_o = st.drive_gfx;
	assign enable_ref_o = st.enable_ref;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	spread_reserved_a: assert property ((cfg.addr == `OFS_SPREAD_HIGH) |-> !cfg.rdata[7])
		else $error("reserved spread bit reads one");
	n_low_lands_a: assert property ((cfg.wr_en && cfg.addr == `OFS_N_LOW) |=>
		(st.n_low == $past(cfg.wdata)))
		else $error("n low byte write lost");
	divider_gate_a: assert property (!st.enable_ref[`POS_MN_ENABLE] |->
		(feedback_divider_o == N_DEFAULT && reference_divider_o == M_DEFAULT))
		else $error("dividers follow registers while disabled");
	ref_drive_write_a: assert property ((cfg.wr_en && cfg.addr == `OFS_ENABLE_REF) |=>
		(enable_ref_o[`POS_REF1_DRIVE] == $past(cfg.wdata[`POS_REF1_DRIVE])
		&& enable_ref_o[4:0] == 5'h00))
		else $error("ref drive byte write wrong");
	spread_field_a: assert property ((cfg.wr_en && cfg.addr == `OFS_SPREAD_HIGH) |=>
		(spread_amount_o[14:8] == $past(cfg.wdata[6:0])))
		else $error("spread high bits wrong");
endmodule : cfg_reg_bank

// *** testbench/smb_host_model.sv ***
// two-wire bus host model that configures the clock synthesizer
`timescale 1ns/1ps
module smb_host_model (
	input wire logic clk_sys_i, // system clock
	input wire logic smb_data_i, // resolved data line
	output logic smb_clk_o, // bus clock
	output logic smb_data_o // 0 pulls data low, 1 releases
);
	localparam int PHASE = 4;

	initial begin
		smb_clk_o = 1'b1;
		smb_data_o = 1'b1;
	end

	// ----------------------------------------------------------------
	// line level steps, all launched just after a falling clk edge
	// ----------------------------------------------------------------
	task automatic gap(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask : gap

	// data moves only well inside the low phase of the bus clock
	task automatic put_bit(input logic b);
		gap(2);
		smb_data_o = b;
		gap(PHASE);
		smb_clk_o = 1'b1;
		gap(PHASE);
		smb_clk_o = 1'b0;
	endtask : put_bit

	task automatic get_bit(output logic b);
		gap(2);
		smb_data_o = 1'b1;
		gap(PHASE);
		smb_clk_o = 1'b1;
		gap(2);
		b = smb_data_i;
		gap(PHASE - 2);
		smb_clk_o = 1'b0;
	endtask : get_bit

	task automatic start_cond;
		gap(2);
		smb_data_o = 1'b1;
		gap(PHASE);
		smb_clk_o = 1'b1;
		gap(PHASE);
		smb_data_o = 1'b0;
		gap(PHASE);
		smb_clk_o = 1'b0;
	endtask : start_cond

	task automatic stop_cond;
		gap(2);
		smb_data_o = 1'b0;
		gap(PHASE);
		smb_clk_o = 1'b1;
		gap(PHASE);
		smb_data_o = 1'b1;
		gap(PHASE);
	endtask : stop_cond

	// ----------------------------------------------------------------
	// byte and transfer level
	// ----------------------------------------------------------------
	task automatic send_byte(input logic [7:0] b, output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			put_bit(b[i]);
		end
		get_bit(a);
		ack = ~a;
	endtask : send_byte

	task automatic recv_byte(output logic [7:0] b, input logic last);
		for (int i = 7; i >= 0; i--) begin
			get_bit(b[i]);
		end
		put_bit(last);
	endtask : recv_byte

	// four bytes from ofs upward, first byte in data[7:0]
	task automatic write_regs(input logic [6:0] dev, input logic [7:0] ofs,
			input logic [31:0] data, output logic [5:0] acks);
		logic a;
		start_cond;
		send_byte({dev, 1'b0}, a);
		acks[5] = a;
		send_byte(ofs, a);
		acks[4] = a;
		for (int k = 0; k < 4; k++) begin
			send_byte(data[8*k +: 8], a);
			acks[3-k] = a;
		end
		stop_cond;
	endtask : write_regs

	task automatic read_regs(input logic [6:0] dev, input logic [7:0] ofs,
			output logic [31:0] data, output logic [2:0] acks);
		logic a;
		start_cond;
		send_byte({dev, 1'b0}, a);
		acks[2] = a;
		send_byte(ofs, a);
		acks[1] = a;
		start_cond;
		send_byte({dev, 1'b1}, a);
		acks[0] = a;
		for (int k = 0; k < 4; k++) begin
			recv_byte(data[8*k +: 8], k == 3);
		end
		stop_cond;
	endtask : read_regs
endmodule : smb_host_model

// *** testbench/clock_synth_config_regs_tb_top.sv ***
// self-checking bench of the clock synthesizer configuration bank
`timescale 1ns/1ps
module clock_synth_config_regs_tb_top;
	localparam logic [6:0] DEV = 7'h5a;
	localparam logic [9:0] N_DEF = 10'h123;
	localparam logic [5:0] M_DEF = 6'h05;
	localparam logic [14:0] SP_DEF = 15'h1234;
	logic clk_sys_i;
	logic rst_n_i;
	logic host_clk;
	logic host_data;
	wire logic smb_data;
	logic data_o, oe_n, ref0, ref1, ref2, usb0, usb1, en_o;
	logic [3:0] gfx;
	logic [9:0] fb;
	logic [5:0] rdiv;
	logic [10:0] mult;
	logic [6:0] divs;
	logic [14:0] spread;
	logic [5:0] bad_acks;
	logic [7:0] shadow [9:14];
	int err_count;
	int num_checks;

	// open-drain data line with pull-up
	assign smb_data = host_data & (oe_n | data_o);

	clock_synth_config_regs #(.SLAVE_ADDR(DEV), .N_DEFAULT(int'(N_DEF)), .M_DEFAULT(int'(M_DEF)),
		.SPREAD_DEFAULT(int'(SP_DEF))) u_clock_synth_config_regs (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .smb_clk_i(host_clk), .smb_data_i(smb_data),
		.smb_data_o(data_o), .smb_data_oe_n_o(oe_n), .ref_out0_drive_select_o(ref0),
		.ref_out1_drive_select_o(ref1), .ref_out2_drive_select_o(ref2),
		.usb_clk0_drive_select_o(usb0), .usb_clk1_drive_select_o(usb1),
		.graphics_freq_select_o(gfx), .divider_program_enable_o(en_o),
		.feedback_divider_o(fb), .reference_divider_o(rdiv), .vco_multiplier_o(mult),
		.vco_divisor_o(divs), .spread_amount_o(spread));

	smb_host_model u_smb_host_model (.clk_sys_i(clk_sys_i), .smb_data_i(smb_data),
		.smb_clk_o(host_clk), .smb_data_o(host_data));

	initial clk_sys_i = 1'b0;
	always #2.5 clk_sys_i = ~clk_sys_i;

	// ----------------------------------------------------------------
	// checking helpers
	// ----------------------------------------------------------------
	task automatic print_verdict;
		if (err_count == 0 && num_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict

	task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask : check_val

	function automatic logic [7:0] wmask(input logic [7:0] ofs);
		case (ofs)
			8'h09: return 8'hef;
			8'h0a: return 8'he0;
			8'h0e: return 8'h7f;
			default: return 8'hff;
		endcase
	endfunction : wmask

	function automatic logic mapped(input logic [7:0] ofs);
		return ofs >= 8'h09 && ofs <= 8'h0e;
	endfunction : mapped

	task automatic reset_shadow;
		shadow[9] = 8'he0;
		shadow[10] = 8'h60;
		shadow[11] = {N_DEF[8], N_DEF[9], M_DEF};
		shadow[12] = N_DEF[7:0];
		shadow[13] = SP_DEF[7:0];
		shadow[14] = {1'b0, SP_DEF[14:8]};
	endtask : reset_shadow

	// pins derived from the byte images; dividers gated by the enable bit
	task automatic check_pins;
		logic [9:0] n;
		logic [5:0] m;
		n = shadow[10][7] ? {shadow[11][6], shadow[11][7], shadow[12]} : N_DEF;
		m = shadow[10][7] ? shadow[11][5:0] : M_DEF;
		check_val({5'h00, ref2, usb1, usb0, gfx, en_o, ref1, ref0,
			fb, rdiv, mult, divs, spread},
			{5'h00, shadow[9][7:5], shadow[9][3:0], shadow[10][7:5], n, m,
			{1'b0, n} + 11'h008, {1'b0, m} + 7'h02, shadow[14][6:0], shadow[13]});
	endtask : check_pins

	task automatic wr(input logic [7:0] ofs, input logic [31:0] data);
		logic [5:0] acks;
		logic [7:0] o;
		u_smb_host_model.write_regs(DEV, ofs, data, acks);
		check_val(64'(acks), 64'h3f);
		for (int k = 0; k < 4; k++) begin
			o = ofs + 8'(k);
			if (mapped(o)) begin
				shadow[o] = data[8*k +: 8] & wmask(o);
			end
		end
		u_smb_host_model.gap(4);
		check_pins;
	endtask : wr

	task automatic rd(input logic [7:0] ofs);
		logic [2:0] acks;
		logic [31:0] d;
		logic [31:0] e;
		logic [7:0] o;
		u_smb_host_model.read_regs(DEV, ofs, d, acks);
		check_val(64'(acks), 64'h7);
		for (int k = 0; k < 4; k++) begin
			o = ofs + 8'(k);
			e[8*k +: 8] = mapped(o) ? shadow[o] : 8'h00;
		end
		check_val(64'(d), 64'(e));
	endtask : rd

	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		err_count = 0;
		num_checks = 0;
		rst_n_i = 1'b0;
		reset_shadow;
		repeat (5) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		repeat (2) @(negedge clk_sys_i);
		check_pins;
		rd(8'h09);
		rd(8'h0b);
		wr(8'h09, 32'ha5_4a_9f_1f);
		rd(8'h09);
		wr(8'h0d, 32'h5a_c3_ff_ff);
		rd(8'h0d);
		rd(8'hfe);
		for (int k = 0; k < 16; k++) begin
			wr(8'h09, {8'(k * 13), 8'(k * 29), k[0], k[2:1], 5'h1f, k[3:1], 1'b1, k[3:0]});
			rd(8'h09);
		end
		u_smb_host_model.write_regs(DEV ^ 7'h01, 8'h09, 32'h0000_0000, bad_acks);
		check_val(64'(bad_acks), 64'h00);
		check_pins;
		rst_n_i = 1'b0;
		repeat (5) @(negedge clk_sys_i);
		rst_n_i = 1'b1;
		reset_shadow;
		repeat (2) @(negedge clk_sys_i);
		check_pins;
		rd(8'h0b);
		print_verdict;
	end

	initial begin
		#400000;
		err_count++;
		print_verdict;
	end
endmodule : clock_synth_config_regs_tb_top
